/* File: design/asram_defines.svh */
// Timing and geometry constants for the static memory controller
`ifndef ASRAM_DEFINES_SVH
`define ASRAM_DEFINES_SVH
`define ASRAM_CLK_NS 50
`define ASRAM_AW 18
`define ASRAM_DW 16
`define ASRAM_POWERUP_US 100
`define ASRAM_POWERUP_CYC ((`ASRAM_POWERUP_US*1000+`ASRAM_CLK_NS-1)/`ASRAM_CLK_NS)
`define ASRAM_ACCESS_NS 8
`define ASRAM_ACCESS_CYC ((`ASRAM_ACCESS_NS+`ASRAM_CLK_NS-1)/`ASRAM_CLK_NS)
`define ASRAM_WSETUP_NS 6
`define ASRAM_WSETUP_CYC ((`ASRAM_WSETUP_NS+`ASRAM_CLK_NS-1)/`ASRAM_CLK_NS)
`define ASRAM_CNT_W 12
`endif

/* File: design/asram_pkg.sv */
// Types for the static memory controller
package asram_pkg;
  typedef enum logic [2:0] {
    ASRAM_POWERUP,
    ASRAM_IDLE,
    ASRAM_RD,
    ASRAM_RD_DONE,
    ASRAM_WR,
    ASRAM_WR_END
  } asram_state_e;
endpackage

/* File: design/asram_ctrl.sv */
// Clocked controller driving an asynchronous 256K x 16 static memory
// Behaviour
// - Chip select low: write strobe low writes, high reads.
// - Read: drive chip select and output enable low, write strobe high.
// - Wait at least 100 us after power before first access.
// - Write needs select, strobe, byte enable low; first rise ends it.
// - Write data set up 4 ns before write end, held to it.
// - Address and controls stable 6 ns before write end.
// - Strobe-ended write with output enable low lasts setup plus float.
// - Address valid no later than chip select falling for reads.
// - Controller does not drive bus while memory drives it.
`timescale 1ns/1ps
`include "asram_defines.svh"
module asram_ctrl (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [1:0] be_i,
  input wire logic [`ASRAM_AW-1:0] addr_i,
  input wire logic [`ASRAM_DW-1:0] wdata_i,
  output logic ready_o,
  output logic ack_o,
  output logic [`ASRAM_DW-1:0] rdata_o,
  output logic [`ASRAM_AW-1:0] word_addr_o,
  output logic chip_sel_n_o,
  output logic write_strobe_n_o,
  output logic out_en_n_o,
  output logic low_byte_lane_n_o,
  output logic high_byte_lane_n_o,
  input wire logic [`ASRAM_DW-1:0] data_bus_i,
  output logic [`ASRAM_DW-1:0] data_bus_o,
  output logic data_bus_oe_o
);
  asram_pkg::asram_state_e state;
  logic [`ASRAM_CNT_W-1:0] cnt;
  logic [1:0] be;

  function automatic logic [`ASRAM_CNT_W-1:0] cyc(input int n);
    cyc = (n < 1) ? `ASRAM_CNT_W'(1) : `ASRAM_CNT_W'(n);
  endfunction

  // Sequencer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= asram_pkg::ASRAM_POWERUP;
      cnt <= '0;
    end else begin
      unique case (state)
        asram_pkg::ASRAM_POWERUP: begin
          // Power-up wait, rounded up
          if (cnt == cyc(`ASRAM_POWERUP_CYC) - `ASRAM_CNT_W'(1)) begin
            state <= asram_pkg::ASRAM_IDLE;
            cnt <= '0;
          end else begin
            cnt <= cnt + `ASRAM_CNT_W'(1);
          end
        end
        asram_pkg::ASRAM_IDLE: begin
          cnt <= '0;
          if (req_i && (be_i != 2'h0)) begin
            state <= we_i ? asram_pkg::ASRAM_WR : asram_pkg::ASRAM_RD;
          end
        end
        asram_pkg::ASRAM_RD: begin
          // Access time covered, rounded up
          if (cnt == cyc(`ASRAM_ACCESS_CYC) - `ASRAM_CNT_W'(1)) begin
            state <= asram_pkg::ASRAM_RD_DONE;
          end else begin
            cnt <= cnt + `ASRAM_CNT_W'(1);
          end
        end
        asram_pkg::ASRAM_RD_DONE: state <= asram_pkg::ASRAM_IDLE;
        asram_pkg::ASRAM_WR: begin
          // Strobe low for setup minimum
          if (cnt == cyc(`ASRAM_WSETUP_CYC) - `ASRAM_CNT_W'(1)) begin
            state <= asram_pkg::ASRAM_WR_END;
          end else begin
            cnt <= cnt + `ASRAM_CNT_W'(1);
          end
        end
        asram_pkg::ASRAM_WR_END: state <= asram_pkg::ASRAM_IDLE;
        default: state <= asram_pkg::ASRAM_IDLE;
      endcase
    end
  end

  // Address and lane capture; address set before select falls
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_addr_o <= '0;
      data_bus_o <= '0;
      be <= 2'h0;
    end else if (state == asram_pkg::ASRAM_IDLE && req_i) begin
      word_addr_o <= addr_i;
      data_bus_o <= wdata_i;
      be <= be_i;
    end
  end

  // Control pins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chip_sel_n_o <= 1'h1;
      write_strobe_n_o <= 1'h1;
      out_en_n_o <= 1'h1;
      low_byte_lane_n_o <= 1'h1;
      high_byte_lane_n_o <= 1'h1;
      data_bus_oe_o <= 1'h0;
    end else begin
      unique case (state)
        asram_pkg::ASRAM_RD: begin
          chip_sel_n_o <= 1'h0;
          out_en_n_o <= 1'h0;
          write_strobe_n_o <= 1'h1;
          low_byte_lane_n_o <= ~be[0];
          high_byte_lane_n_o <= ~be[1];
          data_bus_oe_o <= 1'h0;
        end
        asram_pkg::ASRAM_WR: begin
          chip_sel_n_o <= 1'h0;
          out_en_n_o <= 1'h1;
          write_strobe_n_o <= 1'h0;
          low_byte_lane_n_o <= ~be[0];
          high_byte_lane_n_o <= ~be[1];
          data_bus_oe_o <= 1'h1;
        end
        asram_pkg::ASRAM_WR_END: begin
          // Strobe alone ends the write; data held this edge
          chip_sel_n_o <= 1'h0;
          out_en_n_o <= 1'h1;
          write_strobe_n_o <= 1'h1;
          low_byte_lane_n_o <= ~be[0];
          high_byte_lane_n_o <= ~be[1];
          data_bus_oe_o <= 1'h1;
        end
        default: begin
          chip_sel_n_o <= 1'h1;
          out_en_n_o <= 1'h1;
          write_strobe_n_o <= 1'h1;
          low_byte_lane_n_o <= 1'h1;
          high_byte_lane_n_o <= 1'h1;
          data_bus_oe_o <= 1'h0;
        end
      endcase
    end
  end

  // Read data capture and handshake
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
      ack_o <= 1'h0;
      ready_o <= 1'h0;
    end else begin
      ack_o <= (state == asram_pkg::ASRAM_RD_DONE) ||
               (state == asram_pkg::ASRAM_WR_END);
      ready_o <= (state == asram_pkg::ASRAM_IDLE) && !req_i;
      if (state == asram_pkg::ASRAM_RD_DONE) begin
        rdata_o <= data_bus_i;
      end
    end
  end

  a_no_drive_read: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !out_en_n_o |-> !data_bus_oe_o)
    else $error("Controller drives bus during read");
  a_write_ctrl: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !write_strobe_n_o |-> !chip_sel_n_o && out_en_n_o && data_bus_oe_o
      && !(low_byte_lane_n_o && high_byte_lane_n_o))
    else $error("Write strobe low without full write setup");
  a_read_ctrl: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !out_en_n_o |-> !chip_sel_n_o && write_strobe_n_o)
    else $error("Read controls inconsistent");
  a_write_end: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(write_strobe_n_o) |-> !chip_sel_n_o && data_bus_oe_o
      && $stable(data_bus_o) && $stable(word_addr_o))
    else $error("Write ended badly");
  a_strobe_width: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    $fell(write_strobe_n_o) |-> ##1 write_strobe_n_o)
    else $error("Write strobe width wrong");
  a_addr_stable: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !chip_sel_n_o && !$fell(chip_sel_n_o) |-> $stable(word_addr_o))
    else $error("Address changed while selected");
  a_powerup_idle: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    state == asram_pkg::ASRAM_POWERUP |-> chip_sel_n_o)
    else $error("Access during power-up wait");
  a_read_ack: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    $fell(out_en_n_o) |-> ##1 out_en_n_o && ack_o)
    else $error("Read ack timing wrong");
  a_standby_quiet: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    chip_sel_n_o |-> write_strobe_n_o && out_en_n_o && !data_bus_oe_o)
    else $error("Controls active while deselected");
  c_read: cover property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(out_en_n_o) ##[1:3] ack_o);
  c_write: cover property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(write_strobe_n_o) ##[1:3] ack_o);
  c_low_only: cover property (@(posedge clk_i) disable iff (!nrst_i)
    !write_strobe_n_o && !low_byte_lane_n_o && high_byte_lane_n_o);
  c_read_high: cover property (@(posedge clk_i) disable iff (!nrst_i)
    !out_en_n_o && low_byte_lane_n_o && !high_byte_lane_n_o);
endmodule // asram_ctrl

/* File: bench/asram_mem_model.sv */
// Behavioural model of the 256K x 16 static memory
`timescale 1ns/1ps
module asram_mem_model (
  input wire logic [17:0] word_addr_i,
  input wire logic chip_sel_n_i,
  input wire logic write_strobe_n_i,
  input wire logic out_en_n_i,
  input wire logic low_byte_lane_n_i,
  input wire logic high_byte_lane_n_i,
  input wire logic [15:0] data_bus_i,
  output logic [15:0] data_bus_o
);
  logic [15:0] mem [logic [17:0]];
  logic [15:0] last = 16'h0000;
  logic [15:0] wd, w, r, q;
  logic [17:0] wa;
  logic [1:0] wl;
  wire lo = !low_byte_lane_n_i;
  wire hi = !high_byte_lane_n_i;
  wire sel = !chip_sel_n_i;
  wire wr = sel && !write_strobe_n_i && (lo || hi);
  // Read gating
  wire rd = sel && !out_en_n_i && write_strobe_n_i;
  // Latch write terms while the write is open
  always @* begin
    if (wr) begin
      wa = word_addr_i;
      wd = data_bus_i;
      wl = {hi, lo};
    end
  end
  // Commit on the edge that ends the write
  always @(negedge wr) begin
    if (!$isunknown(wa)) begin
      w = mem.exists(wa) ? mem[wa] : 16'h0000;
      if (wl[0]) w[7:0] = wd[7:0];
      if (wl[1]) w[15:8] = wd[15:8];
      mem[wa] = w;
    end
  end
  // Undriven lanes show the inverse of the last word
  always @* begin
    r = mem.exists(word_addr_i) ? mem[word_addr_i] : 16'h0000;
    q[7:0] = (rd && lo) ? r[7:0] : ~last[7:0];
    q[15:8] = (rd && hi) ? r[15:8] : ~last[15:8];
  end
  assign #5 data_bus_o = q;
  always @(negedge rd) last = q;
endmodule // asram_mem_model

/* File: bench/test_asram_ctrl.sv */
// Self-checking bench for the static memory controller
`timescale 1ns/1ps
module test_asram_ctrl;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_i = 1'b0;
  logic we_i = 1'b0;
  logic [1:0] be_i = 2'h0;
  logic [17:0] addr_i = 18'h00000;
  logic [15:0] wdata_i = 16'h0000;
  logic ready_o, ack_o, cs_n, we_n, oe_n, lb_n, hb_n, oe;
  logic [15:0] rdata_o, dbo, dq;
  logic [17:0] wa;
  wire [15:0] dbi = oe ? dbo : dq;
  int num_errors = 0;
  int checked = 0;
  int n;
  asram_ctrl DUT (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i),
    .we_i(we_i), .be_i(be_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .ready_o(ready_o), .ack_o(ack_o), .rdata_o(rdata_o), .word_addr_o(wa),
    .chip_sel_n_o(cs_n), .write_strobe_n_o(we_n), .out_en_n_o(oe_n),
    .low_byte_lane_n_o(lb_n), .high_byte_lane_n_o(hb_n),
    .data_bus_i(dbi), .data_bus_o(dbo), .data_bus_oe_o(oe));
  asram_mem_model mem (.word_addr_i(wa), .chip_sel_n_i(cs_n),
    .write_strobe_n_i(we_n), .out_en_n_i(oe_n), .low_byte_lane_n_i(lb_n),
    .high_byte_lane_n_i(hb_n), .data_bus_i(dbi), .data_bus_o(dq));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic check(input string s, input logic [31:0] v, e);
    checked++;
    if (v !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic access(input logic w, input logic [1:0] b,
      input logic [17:0] a, input logic [15:0] d);
    n = 0;
    while (ready_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (ready_o !== 1'b1) begin
      check("ready", ready_o, 1'b1);
      results();
    end
    @(posedge clk_i);
    req_i <= 1'b1;
    we_i <= w;
    be_i <= b;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    req_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
      if (n == 1 && b != 2'h0) begin
        check("pins", {cs_n, we_n, oe_n, lb_n, hb_n},
          {1'b0, !w, w, ~b[0], ~b[1]});
        check("addr", wa, a);
      end
    end while (ack_o !== 1'b1 && n < 12);
    if (b != 2'h0) check("ack", n, 2);
    if (ack_o !== 1'b1 && b != 2'h0) results();
  endtask
  task automatic rd(input logic [1:0] b, input logic [17:0] a,
      input logic [15:0] e);
    access(1'b0, b, a, 16'h0000);
    if (b[0]) check("low", rdata_o[7:0], e[7:0]);
    if (b[1]) check("high", rdata_o[15:8], e[15:8]);
  endtask
  task automatic powerup_scn();
    @(posedge clk_i);
    req_i <= 1'b1;
    be_i <= 2'h3;
    repeat (4) @(posedge clk_i);
    req_i <= 1'b0;
    #1;
    check("early cs", cs_n, 1'b1);
    n = 5;
    while (ready_o !== 1'b1 && n < 2100) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("powerup", n >= 2000 && n < 2100, 1'b1);
    if (n == 2100) results();
  endtask
  task automatic lane_scn();
    access(1'b1, 2'h3, 18'h00000, 16'hbeef);
    access(1'b1, 2'h1, 18'h00000, 16'h00c3);
    access(1'b1, 2'h2, 18'h00000, 16'h7700);
    rd(2'h3, 18'h00000, 16'h77c3);
    rd(2'h1, 18'h00000, 16'h77c3);
    rd(2'h2, 18'h00000, 16'h77c3);
  endtask
  task automatic edge_scn();
    access(1'b1, 2'h3, 18'h3ffff, 16'ha55a);
    access(1'b1, 2'h0, 18'h3ffff, 16'h0000);
    check("refused", n, 12);
    rd(2'h3, 18'h3ffff, 16'ha55a);
    rd(2'h3, 18'h00000, 16'h77c3);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    powerup_scn();
    lane_scn();
    edge_scn();
    results();
  end
endmodule // test_asram_ctrl
